// ===== coil_regs_defs.vh
// Purpose: constants for the coil driver control word bank
// Assumes: 32-bit command words, bit 31 is the write flag
// Notes:   header of definitions only
`ifndef COIL_REGS_DEFS_VH
`define COIL_REGS_DEFS_VH

// ----------------------------------------
// Command word fields
// ----------------------------------------
`define CMD_RW_BIT        31
`define CAL_CODE          7'h05
`define CH_WORD_CODE_SP   4'h2
`define CH_WORD_CODE_DI   4'h3
`define CH_SEL_FIRST      2'h1
`define CH_SEL_SECOND     2'h2
`define CAL_RESET         32'h05000000
`define CAL_MODE_BIT      23
`define CAL_SECOND_HI     5
`define CAL_SECOND_LO     4
`define CAL_FIRST_HI      3
`define CAL_FIRST_LO      2
`define SW_LOW_ONLY       2'h1
`define SW_HIGH_ONLY      2'h2
`define SP_EN_BIT         23
`define SP_AL_BIT         22
`define SP_TARGET_W       11
`define DI_EN_BIT         23
`define DI_SYNC_BIT       22
`define DI_FB_BIT         21
`define DI_STEPS_LO       10
`define DI_STEPS_W        6
`define DI_SIZE_W         6
`define AUTOLIM_VALUE     8'd20
`define DIV_M_RESET       6'd32
`define DIV_N_RESET       4'd6
`define DITHER_MAX_PROD   1023

`endif

// ===== dither_gen.v
// Purpose: one channel triangle dither generator
// Assumes: step enable pulse from the shared divider
// Notes:   waveform rises, falls below, returns; one step per pulse
`include "coil_regs_defs.vh"

module dither_gen #(
  parameter STEPS_W = 6,
  parameter SIZE_W  = 6
) (
  // Clock and reset
  input  wire                sys_clk_i,
  input  wire                nrst_i,
  // Control
  input  wire                enable_i,
  input  wire                sync_i,
  input  wire                pwm_start_i,
  input  wire                step_en_i,
  input  wire [STEPS_W-1:0]  steps_i,
  input  wire [SIZE_W-1:0]   size_i,
  // Result
  output reg  signed [11:0]  offset_o,
  output reg                 period_start_o
);

  reg [STEPS_W-1:0] step_cnt;
  reg [1:0]         quarter;
  reg               armed;

  // ----------------------------------------
  // Step sequencer
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_cnt       <= {STEPS_W{1'b0}};
      quarter        <= 2'h0;
      offset_o       <= 12'sh000;
      armed          <= 1'b0;
      period_start_o <= 1'b0;
    end else begin
      period_start_o <= 1'b0;
      if (!enable_i || steps_i == {STEPS_W{1'b0}}) begin
        step_cnt <= {STEPS_W{1'b0}};
        quarter  <= 2'h0;
        offset_o <= 12'sh000;
        armed    <= 1'b0;
      end else if (!armed) begin
        // R10 sync start
        if (!sync_i || pwm_start_i) begin
          armed          <= 1'b1;
          period_start_o <= 1'b1;
        end
      end else if (step_en_i) begin
        // R12 quarter steps
        if (quarter == 2'h0 || quarter == 2'h3)
          offset_o <= offset_o + $signed({6'h00, size_i});
        else
          offset_o <= offset_o - $signed({6'h00, size_i});
        if (step_cnt == steps_i - 1'b1) begin
          step_cnt <= {STEPS_W{1'b0}};
          quarter  <= quarter + 2'h1;
          // Resync each period when aligned to PWM
          if (quarter == 2'h3 && sync_i)
            armed <= 1'b0;
          else if (quarter == 2'h3)
            period_start_o <= 1'b1;
        end else begin
          step_cnt <= step_cnt + 1'b1;
        end
      end
    end
  end

endmodule

// ===== coil_driver_cal_setpoint_dither_regs.v
// Purpose: calibration, setpoint and dither control words of two coils
// Assumes: command words arrive already framed from the serial port
// Notes:   one word per cmd_valid_i pulse, answer next cycle
// Behaviour
// R1 - Bit 31 is 1 for write and 0 for read, and read data shows it as 0.
// R2 - Calibration mode follows bit 23 of the calibration word, off at reset.
// R3 - Second load switches follow bits 5:4: 01 low only, 10 high only.
// R4 - First load switches follow bits 3:2 with the same encoding.
// R5 - Bits 25:24 pick the channel and setpoint bit 23 enables it.
// R6 - A channel enable cannot be set before the diagnosis word is read.
// R7 - Setpoint bit 22 turns on integrator clamp at plus and minus 20.
// R8 - Setpoint bits 10:0 hold the current target, reset zero.
// R9 - Dither word bit 23 turns dither on for the channel, off at reset.
// R10 - Dither bit 22 aligns each dither period to a PWM cycle start.
// R11 - Dither bit 21 picks min/max or average feedback reporting.
// R12 - Dither bits 15:10 give steps per quarter, one per dither tick.
// R13 - Dither bits 5:0 give the step size in target counts.
// R14 - The host keeps steps times size at or below 1023.
// R15 - The dither tick is system clock over (M+1) times 2 to the N.
// R16 - Fixed code bits choose the target word, stored per channel.
// R17 - Per-channel reads return the selected channel's fields and code.
`include "coil_regs_defs.vh"

module coil_driver_cal_setpoint_dither_regs #(
  parameter TARGET_W = 11,
  parameter STEPS_W  = 6,
  parameter SIZE_W   = 6
) (
  // Clock and reset
  input  wire                 sys_clk_i,
  input  wire                 nrst_i,
  // Command port
  input  wire                 cmd_valid_i,
  input  wire [31:0]          cmd_word_i,
  input  wire                 diag_read_i,
  input  wire                 pwm_start_i,
  input  wire [5:0]           div_m_i,
  input  wire [3:0]           div_n_i,
  output reg                  rsp_valid_o,
  output reg  [31:0]          rsp_word_o,
  // First coil
  output reg                  first_coil_high_side_switch_o,
  output reg                  first_coil_low_side_switch_o,
  output reg                  first_coil_enable_o,
  output reg  [7:0]           first_coil_int_limit_o,
  output reg  [TARGET_W-1:0]  first_coil_target_o,
  output reg  signed [11:0]   first_coil_dither_o,
  output reg                  first_coil_feedback_report_select_o,
  // Second coil
  output reg                  second_coil_high_side_switch_o,
  output reg                  second_coil_low_side_switch_o,
  output reg                  second_coil_enable_o,
  output reg  [7:0]           second_coil_int_limit_o,
  output reg  [TARGET_W-1:0]  second_coil_target_o,
  output reg  signed [11:0]   second_coil_dither_o,
  output reg                  second_coil_feedback_report_select_o,
  // Mode
  output reg                  calibration_mode_enable_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg               calibration_mode_enable;
  reg [1:0]         first_load_manual_switch_state;
  reg [1:0]         second_load_manual_switch_state;
  reg               diag_seen;
  reg [1:0]         ch_en;
  reg [1:0]         ch_al;
  reg [TARGET_W-1:0] ch_target [0:1];
  reg [1:0]         di_en;
  reg [1:0]         di_sync;
  reg [1:0]         feedback_report_select;
  reg [STEPS_W-1:0] di_steps [0:1];
  reg [SIZE_W-1:0]  di_size  [0:1];
  reg [31:0]        next_rsp;
  reg [5:0]         m_cnt;
  reg [15:0]        n_cnt;
  reg               step_en;
  wire signed [11:0] dith0;
  wire signed [11:0] dith1;

  // R16 decode codes
  wire is_cal = cmd_word_i[30:24] == `CAL_CODE;
  wire is_sp  = cmd_word_i[30:27] == `CH_WORD_CODE_SP;
  wire is_di  = cmd_word_i[30:27] == `CH_WORD_CODE_DI;
  wire [1:0] sel = cmd_word_i[25:24];
  // R5 channel select; 00 and 11 address no channel
  wire ch0 = sel == `CH_SEL_FIRST;
  wire ch1 = sel == `CH_SEL_SECOND;
  wire idx = ch1;
  // R1 write flag
  wire wr  = cmd_valid_i && cmd_word_i[`CMD_RW_BIT];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      calibration_mode_enable         <= 1'b0;
      first_load_manual_switch_state  <= 2'h0;
      second_load_manual_switch_state <= 2'h0;
      diag_seen    <= 1'b0;
      ch_en        <= 2'h0;
      ch_al        <= 2'h3;
      ch_target[0] <= {TARGET_W{1'b0}};
      ch_target[1] <= {TARGET_W{1'b0}};
      di_en        <= 2'h0;
      di_sync      <= 2'h0;
      feedback_report_select <= 2'h0;
      di_steps[0]  <= {STEPS_W{1'b0}};
      di_steps[1]  <= {STEPS_W{1'b0}};
      di_size[0]   <= {SIZE_W{1'b0}};
      di_size[1]   <= {SIZE_W{1'b0}};
    end else begin
      if (diag_read_i)
        diag_seen <= 1'b1;
      if (wr && is_cal) begin
        // R2 mode bit
        calibration_mode_enable <= cmd_word_i[`CAL_MODE_BIT];
        // R3 second load
        second_load_manual_switch_state <=
          cmd_word_i[`CAL_SECOND_HI:`CAL_SECOND_LO];
        // R4 first load
        first_load_manual_switch_state <=
          cmd_word_i[`CAL_FIRST_HI:`CAL_FIRST_LO];
      end else if (wr && is_sp && (ch0 || ch1)) begin
        // R6 enable gated
        ch_en[idx] <= cmd_word_i[`SP_EN_BIT] & diag_seen;
        // R7 autolimit
        ch_al[idx] <= cmd_word_i[`SP_AL_BIT];
        // R8 target
        ch_target[idx] <= cmd_word_i[TARGET_W-1:0];
      end else if (wr && is_di && (ch0 || ch1)) begin
        // R9 dither enable
        di_en[idx]   <= cmd_word_i[`DI_EN_BIT];
        // R10 sync bit
        di_sync[idx] <= cmd_word_i[`DI_SYNC_BIT];
        // R11 feedback mode
        feedback_report_select[idx] <= cmd_word_i[`DI_FB_BIT];
        // R12 steps
        di_steps[idx] <= cmd_word_i[`DI_STEPS_LO+STEPS_W-1:`DI_STEPS_LO];
        // R13 step size
        di_size[idx]  <= cmd_word_i[SIZE_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    next_rsp = 32'h00000000;
    // R1 flag reads 0
    if (is_cal) begin
      next_rsp[30:24] = `CAL_CODE;
      next_rsp[`CAL_MODE_BIT] = calibration_mode_enable;
      next_rsp[`CAL_SECOND_HI:`CAL_SECOND_LO] =
        second_load_manual_switch_state;
      next_rsp[`CAL_FIRST_HI:`CAL_FIRST_LO] = first_load_manual_switch_state;
    end else if (is_sp && (ch0 || ch1)) begin
      // R17 selected channel
      next_rsp[30:27] = `CH_WORD_CODE_SP;
      next_rsp[25:24] = sel;
      next_rsp[`SP_EN_BIT] = ch_en[idx];
      next_rsp[`SP_AL_BIT] = ch_al[idx];
      next_rsp[TARGET_W-1:0] = ch_target[idx];
    end else if (is_di && (ch0 || ch1)) begin
      // R17 selected channel
      next_rsp[30:27] = `CH_WORD_CODE_DI;
      next_rsp[25:24] = sel;
      next_rsp[`DI_EN_BIT] = di_en[idx];
      next_rsp[`DI_SYNC_BIT] = di_sync[idx];
      next_rsp[`DI_FB_BIT] = feedback_report_select[idx];
      next_rsp[`DI_STEPS_LO+STEPS_W-1:`DI_STEPS_LO] = di_steps[idx];
      next_rsp[SIZE_W-1:0] = di_size[idx];
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_word_o  <= 32'h00000000;
    end else begin
      rsp_valid_o <= cmd_valid_i;
      if (cmd_valid_i)
        rsp_word_o <= next_rsp;
    end
  end

  // ----------------------------------------
  // Dither tick divider
  // ----------------------------------------
  // R15 divide by (M+1)*2^N
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m_cnt   <= 6'h00;
      n_cnt   <= 16'h0000;
      step_en <= 1'b0;
    end else begin
      step_en <= 1'b0;
      if (n_cnt >= ((16'h0001 << div_n_i) - 16'h0001)) begin
        n_cnt <= 16'h0000;
        if (m_cnt >= div_m_i) begin
          m_cnt   <= 6'h00;
          step_en <= 1'b1;
        end else begin
          m_cnt <= m_cnt + 6'h01;
        end
      end else begin
        n_cnt <= n_cnt + 16'h0001;
      end
    end
  end

  // R14 host keeps product in range, no clamp here
  dither_gen #(.STEPS_W(STEPS_W), .SIZE_W(SIZE_W)) u_dith0 (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .enable_i       (di_en[0]),
    .sync_i         (di_sync[0]),
    .pwm_start_i    (pwm_start_i),
    .step_en_i      (step_en),
    .steps_i        (di_steps[0]),
    .size_i         (di_size[0]),
    .offset_o       (dith0),
    .period_start_o ()
  );

  dither_gen #(.STEPS_W(STEPS_W), .SIZE_W(SIZE_W)) u_dith1 (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .enable_i       (di_en[1]),
    .sync_i         (di_sync[1]),
    .pwm_start_i    (pwm_start_i),
    .step_en_i      (step_en),
    .steps_i        (di_steps[1]),
    .size_i         (di_size[1]),
    .offset_o       (dith1),
    .period_start_o ()
  );

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_coil_high_side_switch_o        <= 1'b0;
      first_coil_low_side_switch_o         <= 1'b0;
      second_coil_high_side_switch_o       <= 1'b0;
      second_coil_low_side_switch_o        <= 1'b0;
      first_coil_enable_o                  <= 1'b0;
      second_coil_enable_o                 <= 1'b0;
      first_coil_int_limit_o               <= 8'h00;
      second_coil_int_limit_o              <= 8'h00;
      first_coil_target_o                  <= {TARGET_W{1'b0}};
      second_coil_target_o                 <= {TARGET_W{1'b0}};
      first_coil_dither_o                  <= 12'sh000;
      second_coil_dither_o                 <= 12'sh000;
      first_coil_feedback_report_select_o  <= 1'b0;
      second_coil_feedback_report_select_o <= 1'b0;
      calibration_mode_enable_o            <= 1'b0;
    end else begin
      calibration_mode_enable_o <= calibration_mode_enable;
      // R4 first load switches
      first_coil_high_side_switch_o <= calibration_mode_enable &&
        first_load_manual_switch_state == `SW_HIGH_ONLY;
      first_coil_low_side_switch_o <= calibration_mode_enable &&
        first_load_manual_switch_state == `SW_LOW_ONLY;
      // R3 second load switches
      second_coil_high_side_switch_o <= calibration_mode_enable &&
        second_load_manual_switch_state == `SW_HIGH_ONLY;
      second_coil_low_side_switch_o <= calibration_mode_enable &&
        second_load_manual_switch_state == `SW_LOW_ONLY;
      first_coil_enable_o  <= ch_en[0];
      second_coil_enable_o <= ch_en[1];
      // R7 zero means no clamp
      first_coil_int_limit_o  <= ch_al[0] ? `AUTOLIM_VALUE : 8'h00;
      second_coil_int_limit_o <= ch_al[1] ? `AUTOLIM_VALUE : 8'h00;
      first_coil_target_o  <= ch_target[0];
      second_coil_target_o <= ch_target[1];
      first_coil_dither_o  <= dith0;
      second_coil_dither_o <= dith1;
      first_coil_feedback_report_select_o  <= feedback_report_select[0];
      second_coil_feedback_report_select_o <= feedback_report_select[1];
    end
  end

endmodule

// ===== coil_regs_properties.sv
// Purpose: port-level checks of the coil control word bank
// Assumes: answer one cycle after a command, effects two cycles after
// Notes:   bound to the top module, sees its ports only
module coil_regs_properties #(
  parameter TARGET_W = 11
) (
  // Clock, reset and command port
  input wire logic                sys_clk_i,
  input wire logic                nrst_i,
  input wire logic                cmd_valid_i,
  input wire logic [31:0]         cmd_word_i,
  input wire logic                diag_read_i,
  input wire logic                rsp_valid_o,
  input wire logic [31:0]         rsp_word_o,
  // Coil outputs
  input wire logic                first_coil_high_side_switch_o,
  input wire logic                first_coil_low_side_switch_o,
  input wire logic                first_coil_enable_o,
  input wire logic [7:0]          first_coil_int_limit_o,
  input wire logic [TARGET_W-1:0] first_coil_target_o,
  input wire logic                second_coil_high_side_switch_o,
  input wire logic                second_coil_low_side_switch_o,
  input wire logic                second_coil_enable_o,
  input wire logic                second_coil_feedback_report_select_o,
  input wire logic                calibration_mode_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic diag_seen;
  wire  wr = cmd_valid_i && cmd_word_i[31];
  wire  cal_wr = wr && cmd_word_i[30:24] == 7'h05;
  wire  sp1 = wr && cmd_word_i[30:27] == 4'h2 && cmd_word_i[25:24] == 2'h1;
  wire  di2 = wr && cmd_word_i[30:27] == 4'h3 && cmd_word_i[25:24] == 2'h2;
  wire  f_on = first_coil_high_side_switch_o || first_coil_low_side_switch_o;
  wire  s_on = second_coil_high_side_switch_o || second_coil_low_side_switch_o;

  // Unlock seen, kept sticky
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      diag_seen <= 1'b0;
    else if (diag_read_i)
      diag_seen <= 1'b1;
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_rsp_next_cycle: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("no answer one cycle after a command");
  a_rsp_has_cause: assert property (rsp_valid_o |-> $past(cmd_valid_i))
    else $error("answer without a command");
  a_read_bit_clear: assert property (rsp_valid_o |-> !rsp_word_o[31])
    else $error("access bit set in read data");
  a_cal_mode_follow: assert property (cal_wr |-> ##2
    calibration_mode_enable_o == $past(cmd_word_i[23], 2))
    else $error("calibration mode not taken from write");
  a_switch_safe: assert property (!(first_coil_high_side_switch_o &&
    first_coil_low_side_switch_o) && !(second_coil_high_side_switch_o &&
    second_coil_low_side_switch_o) && (calibration_mode_enable_o ||
    !(f_on || s_on)))
    else $error("switch drive outside calibration or both on");
  a_enable_locked: assert property (!diag_seen |->
    !first_coil_enable_o && !second_coil_enable_o)
    else $error("channel enabled before diagnosis read");
  a_target_follow: assert property (sp1 |-> ##2
    first_coil_target_o == $past(cmd_word_i[TARGET_W-1:0], 2))
    else $error("first target not taken from write");
  a_limit_follow: assert property (sp1 |-> ##2 first_coil_int_limit_o ==
    ($past(cmd_word_i[22], 2) ? 8'h14 : 8'h00))
    else $error("first integrator limit wrong");
  a_report_follow: assert property (di2 |-> ##2
    second_coil_feedback_report_select_o == $past(cmd_word_i[21], 2))
    else $error("second report select not taken from write");
endmodule

bind coil_driver_cal_setpoint_dither_regs coil_regs_properties #(
  .TARGET_W(TARGET_W)
) u_chk (
  .sys_clk_i, .nrst_i, .cmd_valid_i, .cmd_word_i, .diag_read_i,
  .rsp_valid_o, .rsp_word_o, .first_coil_high_side_switch_o,
  .first_coil_low_side_switch_o, .first_coil_enable_o,
  .first_coil_int_limit_o, .first_coil_target_o,
  .second_coil_high_side_switch_o, .second_coil_low_side_switch_o,
  .second_coil_enable_o, .second_coil_feedback_report_select_o,
  .calibration_mode_enable_o
);

// ===== coil_host_model.sv
// Purpose: host side of the serial register port
// Assumes: one word per command, answer one cycle after it is taken
// Notes:   released word lines show the inverse, never the old value
module coil_host_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Command side
  output logic             cmd_valid_o,
  output logic [31:0]      cmd_word_o,
  output logic             diag_read_o,
  input  wire logic        rsp_valid_i,
  input  wire logic [31:0] rsp_word_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_word_o = 32'h0;
    diag_read_o = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_word_o = w;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_word_o = ~w;
    r = rsp_valid_i ? rsp_word_i : 32'hxxxxxxxx;
  endtask
  task automatic diag_pulse();
    @(posedge sys_clk_i);
    #1;
    diag_read_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    diag_read_o = 1'b0;
  endtask
endmodule

// ===== coil_driver_cal_setpoint_dither_regs_test.sv
// Purpose: command sequences against the coil control word bank
// Assumes: 125 MHz clock, effects two cycles after a command is taken
// Notes:   PWM start pulsed once to release the aligned dither
module test_coil_driver_cal_setpoint_dither_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic [5:0]        div_m_i = 6'h01;
  logic [3:0]        div_n_i = 4'h1;
  logic              pwm_start_i = 1'b0;
  wire               cv, dr, rv, fhs, fls, fen, ffb, shs, sls, sen, sfb, cm;
  wire  [31:0]       cw, rw;
  wire  [7:0]        flim, slim;
  wire  [10:0]       ftg, stg;
  wire  signed [11:0] fdi, sdi;
  int                n_errors = 0;
  int                tests_run = 0;
  int                k;
  logic [31:0]       r;

  always #4 sys_clk_i = ~sys_clk_i;

  coil_host_model host_u (.sys_clk_i(sys_clk_i), .cmd_valid_o(cv),
    .cmd_word_o(cw), .diag_read_o(dr), .rsp_valid_i(rv), .rsp_word_i(rw));

  coil_driver_cal_setpoint_dither_regs dut_u (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .cmd_valid_i(cv), .cmd_word_i(cw), .diag_read_i(dr),
    .pwm_start_i(pwm_start_i), .div_m_i(div_m_i), .div_n_i(div_n_i),
    .rsp_valid_o(rv), .rsp_word_o(rw),
    .first_coil_high_side_switch_o(fhs), .first_coil_low_side_switch_o(fls),
    .first_coil_enable_o(fen), .first_coil_int_limit_o(flim),
    .first_coil_target_o(ftg), .first_coil_dither_o(fdi),
    .first_coil_feedback_report_select_o(ffb),
    .second_coil_high_side_switch_o(shs), .second_coil_low_side_switch_o(sls),
    .second_coil_enable_o(sen), .second_coil_int_limit_o(slim),
    .second_coil_target_o(stg), .second_coil_dither_o(sdi),
    .second_coil_feedback_report_select_o(sfb),
    .calibration_mode_enable_o(cm));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write, then let its effects land
  task automatic wr(input logic [31:0] w);
    host_u.xfer(w, r);
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rd(input logic [31:0] w, input logic [31:0] exp);
    host_u.xfer(w, r);
    check(r, exp);
  endtask
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    rd(32'h05000000, 32'h05000000);
    rd(32'h11000000, 32'h11400000);
    rd(32'h1a000000, 32'h1a000000);
    check({24'h0, flim}, 32'h14);
    $display("test reset values done");
    wr(32'h91c007ff);
    check({31'h0, fen}, 32'h0);
    rd(32'h11000000, 32'h114007ff);
    host_u.diag_pulse();
    wr(32'h91c007ff);
    check({31'h0, fen}, 32'h1);
    check({21'h0, ftg}, 32'h7ff);
    rd(32'h11000000, 32'h11c007ff);
    wr(32'h92000155);
    check({16'h0, slim, flim}, 32'h0014);
    check({20'h0, stg, sen}, {20'h0, 12'h2aa});
    rd(32'h12000155, 32'h12000155);
    wr(32'h90800001);
    check({10'h0, ftg, stg}, {10'h0, 11'h7ff, 11'h155});
    rd(32'h13000000, 32'h0);
    rd(32'h7f000000, 32'h0);
    $display("test channel words done");
    for (int c = 0; c < 4; c++) begin
      wr(32'h85800000 | (c << 4) | ((3 - c) << 2));
      check({cm, shs, sls, fhs, fls},
        {1'b1, c == 2, c == 1, c == 1, c == 2});
    end
    wr(32'h85000024);
    check({cm, shs, sls, fhs, fls}, 32'h0);
    rd(32'h05000000, 32'h05000024);
    $display("test calibration done");
    // Two steps of five keep the product far under the limit
    wr(32'h99a00805);
    check({31'h0, ffb}, 32'h1);
    rd(32'h19000000, 32'h19a00805);
    k = 0;
    while (fdi !== 12'sd5 && k < 200) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    k = 0;
    while (fdi !== 12'sd10 && k < 200) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    check(k, 4);
    wr(32'h99000805);
    // Dither offset passes one more register stage
    @(posedge sys_clk_i);
    #1;
    check({20'h0, fdi}, 32'h0);
    // Aligned dither holds until a PWM cycle starts
    wr(32'h9ac00403);
    repeat (20) @(posedge sys_clk_i);
    #1;
    check({20'h0, sdi}, 32'h0);
    pwm_start_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    pwm_start_i = 1'b0;
    k = 0;
    while (sdi !== 12'sd3 && k < 20) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    check({20'h0, sdi}, 32'h3);
    wr(32'h9a200000);
    @(posedge sys_clk_i);
    #1;
    check({31'h0, sfb}, 32'h1);
    check({20'h0, sdi}, 32'h0);
    $display("test dither done");
    print_verdict();
  end
endmodule
